// ===== core/tc_timer_top.sv
// timer/counter with shared prescaler and AXI4-Lite register slave
`default_nettype none

// Summary of operation
// - internal source counts once per instruction cycle while the prescaler is on the watchdog
// - timer write stalls counting two instruction cycles
// - source select one counts external pin edges
// - edge select: zero rising, one falling
// - prescaler serves timer or watchdog, never both
// - ratio field divides 1:2 up to 1:256
// - wrap FFh to 00h sets overflow flag
// - enable bit gates request, flag still sets
// - timer stops during sleep, no wake-up
// - prescaler or pin sampled at Q2, Q4
// - increment 3 to 7 Tosc after edge
// - prescaler count hidden, cleared only indirectly
// - timer write clears prescaler when assigned
// - watchdog clear clears watchdog, and prescaler when assigned to it
// - assignment may change while timer runs
module tc_timer_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite slave
  input  wire logic [tc_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [tc_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [tc_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [tc_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // pin and neighbours
  input  wire logic                          external_count_input,
  input  wire logic                          watchdog_tick,
  output logic                               watchdog_timeout,
  output logic                               watchdog_clear,
  output logic                               timer_irq_req,
  output logic [tc_pkg::PINDIR_W-1:0]        pin_direction
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  tc_pkg::tc_phase_t            phase_ff;      // instruction-cycle phase
  tc_pkg::tc_phase_t            nxt_phase;
  logic [7:0]                   timer_ff;      // timer_count
  logic [7:0]                   intctl_ff;     // interrupt_control
  logic [7:0]                   nxt_intctl;
  logic [7:0]                   option_ff;     // option_config
  logic [tc_pkg::PINDIR_W-1:0]  pindir_ff;     // pin_direction
  logic                         sleep_ff;      // sleep mode
  logic                         wdclr_ff;      // watchdog clear pulse
  logic                         wdto_ff;       // watchdog tick out
  logic [1:0]                   inhib_ff;      // stall after timer write
  logic                         ext_meta_ff;   // synchroniser stage one
  logic                         ext_sync_ff;   // synchroniser stage two
  logic                         ext_prev_ff;   // for edge detection
  logic                         smp_ff;        // Q2/Q4 sample
  logic                         smp_prev_ff;   // previous sample
  // bus state
  logic                         aw_ok_ff;      // write address held
  logic [tc_pkg::ADDR_W-1:0]    awaddr_ff;
  logic                         w_ok_ff;       // write data held
  logic [7:0]                   wdata_ff;      // only the low lane is used
  logic                         wlane_ff;      // low lane strobe
  logic                         bvalid_ff;
  logic [1:0]                   bresp_ff;
  logic                         rvalid_ff;
  logic [tc_pkg::DATA_W-1:0]    rdata_ff;
  logic [1:0]                   rresp_ff;
  logic [tc_pkg::DATA_W-1:0]    rd_mux;
  logic                         rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  function automatic logic hit(input logic [tc_pkg::ADDR_W-1:0] a,
                               input logic [7:0] idx);
    return a == {2'h0, idx, 2'h0};
  endfunction

  wire wr_fire   = aw_ok_ff && w_ok_ff && !bvalid_ff;    // write takes effect
  wire wr_en     = wr_fire && wlane_ff;                   // low lane enabled
  wire wr_tmr    = wr_en && hit(awaddr_ff, tc_pkg::IDX_TIMER);
  wire wr_intctl = wr_en && hit(awaddr_ff, tc_pkg::IDX_INTCTL);
  wire wr_option = wr_en && hit(awaddr_ff, tc_pkg::IDX_OPTION);
  wire wr_pindir = wr_en && hit(awaddr_ff, tc_pkg::IDX_PINDIR);
  wire wr_ctrl   = wr_en && hit(awaddr_ff, tc_pkg::IDX_CTRL);
  wire wr_map    = hit(awaddr_ff, tc_pkg::IDX_TIMER)
                || hit(awaddr_ff, tc_pkg::IDX_INTCTL)
                || hit(awaddr_ff, tc_pkg::IDX_OPTION)
                || hit(awaddr_ff, tc_pkg::IDX_PINDIR)
                || hit(awaddr_ff, tc_pkg::IDX_CTRL);
  wire wd_clr_req = wr_ctrl && wdata_ff[tc_pkg::CTRL_WDC_BIT];

  // option fields
  wire                     opt_cs   = option_ff[tc_pkg::OPT_CS_BIT];
  wire                     opt_edge = option_ff[tc_pkg::OPT_EDGE_BIT];
  wire                     opt_psa  = option_ff[tc_pkg::OPT_PSA_BIT];
  wire [tc_pkg::PS_W-1:0]  opt_ps   = option_ff[tc_pkg::OPT_PS_LSB +: tc_pkg::PS_W];

  //////////////////////////////////////////////////////////////////////////////
  // instruction-cycle phases
  always_comb begin
    case (phase_ff)
      tc_pkg::PH_Q1: nxt_phase = tc_pkg::PH_Q2;
      tc_pkg::PH_Q2: nxt_phase = tc_pkg::PH_Q3;
      tc_pkg::PH_Q3: nxt_phase = tc_pkg::PH_Q4;
      default:       nxt_phase = tc_pkg::PH_Q1;
    endcase
  end

  wire q2 = phase_ff == tc_pkg::PH_Q2;
  wire q4 = phase_ff == tc_pkg::PH_Q4;        // last phase ends the cycle

  //////////////////////////////////////////////////////////////////////////////
  // external pin path
  // the edge select flips polarity so one rising detector serves both edges
  wire ext_lvl  = ext_sync_ff ^ opt_edge;
  wire ext_rise = ext_lvl && !ext_prev_ff;

  // prescaler source: watchdog ticks or the timer's own source
  wire psc_level;
  wire psc_tick;
  wire psc_src  = opt_psa ? watchdog_tick
                : (sleep_ff ? 1'b0 : (opt_cs ? ext_rise : q4));
  wire psc_clr  = (wr_tmr && !opt_psa)
               || (wd_clr_req && opt_psa);

  tc_prescaler u_psc (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clr       (psc_clr),
    .cnt_en    (psc_src),
    .ratio     (opt_ps),
    .out_level (psc_level),
    .tick      (psc_tick)
  );

  // the raw pin stands in for the prescaler output when not assigned
  wire smp_src = opt_psa ? ext_lvl : psc_level;
  wire ext_inc = smp_ff && !smp_prev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // increment selection
  wire inc_src = opt_cs ? ext_inc
               : (opt_psa ? q4 : psc_tick);
  // a write in the same cycle wins over any count
  wire inc_now = inc_src && !sleep_ff
              && (inhib_ff == 2'h0) && !wr_tmr;
  wire ovf_set = inc_now && (timer_ff == 8'hFF);

  //////////////////////////////////////////////////////////////////////////////
  // interrupt_control next value, the overflow set wins over a write
  always_comb begin
    nxt_intctl = intctl_ff;
    if (wr_intctl) begin
      nxt_intctl = wdata_ff;
    end
    if (ovf_set) begin
      nxt_intctl[tc_pkg::INT_FLAG_BIT] = 1'b1;
    end
  end

  // request only while enabled; flag is kept regardless
  assign timer_irq_req = intctl_ff[tc_pkg::INT_FLAG_BIT]
                      && intctl_ff[tc_pkg::INT_EN_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // phase and synchroniser flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff    <= tc_pkg::PH_Q1;
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= tc_pkg::RST_OPTION[tc_pkg::OPT_EDGE_BIT];  // idle level, no false edge
    end else begin
      phase_ff    <= nxt_phase;
      ext_meta_ff <= external_count_input;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample the divided level, or the pin level when the prescaler is on the watchdog, twice per instruction cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_ff      <= tc_pkg::RST_OPTION[tc_pkg::OPT_EDGE_BIT];  // reset option routes pin straight in
      smp_prev_ff <= tc_pkg::RST_OPTION[tc_pkg::OPT_EDGE_BIT];  // so no count right after reset
    end else begin
      if (q2 || q4) begin
        smp_ff <= smp_src;
      end
      smp_prev_ff <= smp_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stall counter after a timer write, counts instruction cycles down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhib_ff <= 2'h0;
    end else if (wr_tmr) begin
      inhib_ff <= tc_pkg::INHIBIT_CYC;
    end else if (q4 && (inhib_ff != 2'h0)) begin
      inhib_ff <= inhib_ff - 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timer count; option changes never stop it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ff <= tc_pkg::RST_TIMER;
    end else if (wr_tmr) begin
      timer_ff <= wdata_ff;
    end else if (inc_now) begin
      timer_ff <= timer_ff + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intctl_ff <= tc_pkg::RST_INTCTL;
      option_ff <= tc_pkg::RST_OPTION;
      pindir_ff <= tc_pkg::RST_PINDIR;
      sleep_ff  <= 1'b0;
    end else begin
      intctl_ff <= nxt_intctl;
      if (wr_option) begin
        option_ff <= wdata_ff;
      end
      if (wr_pindir) begin
        pindir_ff <= wdata_ff[tc_pkg::PINDIR_W-1:0];
      end
      if (wr_ctrl) begin
        sleep_ff <= wdata_ff[tc_pkg::CTRL_SLP_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // watchdog side: clear pulse and (possibly divided) tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdclr_ff <= 1'b0;
      wdto_ff  <= 1'b0;
    end else begin
      wdclr_ff <= wd_clr_req;
      wdto_ff  <= opt_psa ? psc_tick : watchdog_tick;
    end
  end

  assign watchdog_clear   = wdclr_ff;
  assign watchdog_timeout = wdto_ff;
  assign pin_direction    = pindir_ff;

  //////////////////////////////////////////////////////////////////////////////
  // write channel: address and data in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff  <= 1'b0;
      awaddr_ff <= '0;
      w_ok_ff   <= 1'b0;
      wdata_ff  <= 8'h00;
      wlane_ff  <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= tc_pkg::RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? tc_pkg::RESP_OK : tc_pkg::RESP_DE;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // one write under way; new items wait until the answer is taken
  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  //////////////////////////////////////////////////////////////////////////////
  // read mux; the prescaler has no address at all
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    if (hit(s_axi_araddr, tc_pkg::IDX_TIMER)) begin
      rd_mux[7:0] = timer_ff;
    end else if (hit(s_axi_araddr, tc_pkg::IDX_INTCTL)) begin
      rd_mux[7:0] = intctl_ff;
    end else if (hit(s_axi_araddr, tc_pkg::IDX_OPTION)) begin
      rd_mux[7:0] = option_ff;
    end else if (hit(s_axi_araddr, tc_pkg::IDX_PINDIR)) begin
      rd_mux[tc_pkg::PINDIR_W-1:0] = pindir_ff;
    end else if (hit(s_axi_araddr, tc_pkg::IDX_CTRL)) begin
      rd_mux[tc_pkg::CTRL_SLP_BIT] = sleep_ff;             // strobe reads zero
    end else begin
      rd_hit = 1'b0;                                       // unmapped
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel, data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= tc_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_hit ? tc_pkg::RESP_OK : tc_pkg::RESP_DE;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  int_count_a: assert property (
    !opt_cs && opt_psa && q4 && !sleep_ff && inhib_ff == 2'h0 && !wr_tmr
    |=> timer_ff == 8'($past(timer_ff) + 8'h01)) else $error("no cycle count");

  write_stall_a: assert property (
    wr_tmr |=> !inc_now [*4]) else $error("count during write stall");

  ext_count_a: assert property (
    opt_cs && ext_inc && !sleep_ff && inhib_ff == 2'h0 && !wr_tmr
    |=> timer_ff == 8'($past(timer_ff) + 8'h01)) else $error("edge not counted");

  overflow_set_a: assert property (
    inc_now && timer_ff == 8'hFF
    |=> intctl_ff[tc_pkg::INT_FLAG_BIT] && timer_ff == 8'h00)
    else $error("wrap did not set flag");

  irq_gate_a: assert property (
    !intctl_ff[tc_pkg::INT_EN_BIT] |-> !timer_irq_req) else $error("masked request");

  flag_keep_a: assert property (
    intctl_ff[tc_pkg::INT_FLAG_BIT] && !wr_intctl
    |=> intctl_ff[tc_pkg::INT_FLAG_BIT]) else $error("flag cleared by hardware");

  sleep_stop_a: assert property (
    sleep_ff && !wr_tmr |=> $stable(timer_ff)) else $error("timer ran in sleep");

  psc_wrclr_a: assert property (
    wr_tmr && !opt_psa |=> u_psc.cnt_ff == 8'h00) else $error("write kept prescaler");

  psc_wdclr_a: assert property (
    wd_clr_req && opt_psa |=> u_psc.cnt_ff == 8'h00 && watchdog_clear)
    else $error("watchdog clear missed");

  one_step_a: assert property (
    !wr_tmr |=> $stable(timer_ff) || timer_ff == 8'($past(timer_ff) + 8'h01))
    else $error("timer jumped");

  overflow_c: cover property (ovf_set);
  ext_inc_c:  cover property (opt_cs && inc_now);
  stall_c:    cover property (wr_tmr ##[1:12] inc_now);
  wd_clr_c:   cover property (wd_clr_req && opt_psa);

endmodule

`default_nettype wire

// ===== pkg/tc_pkg.sv
// constants and types shared by the timer/counter block
`default_nettype none

package tc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int          ADDR_W  = 12;     // byte address width of the slave
  localparam int          DATA_W  = 32;     // bus data width
  localparam logic [1:0]  RESP_OK = 2'h0;   // okay answer
  localparam logic [1:0]  RESP_DE = 2'h3;   // unmapped address answer

  //////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0]  IDX_TIMER  = 8'h01;  // timer_count
  localparam logic [7:0]  IDX_INTCTL = 8'h0B;  // interrupt_control
  localparam logic [7:0]  IDX_OPTION = 8'h81;  // option_config
  localparam logic [7:0]  IDX_PINDIR = 8'h85;  // pin_direction
  localparam logic [7:0]  IDX_CTRL   = 8'h90;  // sleep and watchdog clear

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int OPT_CS_BIT    = 5;  // clock_source_select
  localparam int OPT_EDGE_BIT  = 4;  // count_edge_select
  localparam int OPT_PSA_BIT   = 3;  // prescaler_assign
  localparam int OPT_PS_LSB    = 0;  // prescale_ratio low bit
  localparam int PS_W          = 3;  // prescale_ratio width
  localparam int INT_FLAG_BIT  = 2;  // timer_overflow_flag
  localparam int INT_EN_BIT    = 5;  // timer_irq_enable
  localparam int CTRL_SLP_BIT  = 0;  // sleep mode
  localparam int CTRL_WDC_BIT  = 1;  // watchdog_clear_instr strobe
  localparam int PINDIR_W      = 6;  // implemented pin_direction bits

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]          RST_TIMER  = 8'h00;
  localparam logic [7:0]          RST_INTCTL = 8'h00;
  localparam logic [7:0]          RST_OPTION = 8'hFF;
  localparam logic [PINDIR_W-1:0] RST_PINDIR = 6'h3F;

  //////////////////////////////////////////////////////////////////////////////
  // timing: the oscillator period is the bus clock period
  localparam int         CLK_NS      = 4;              // aclk period in ns
  localparam int         TOSC_NS     = 4;              // oscillator period in ns
  localparam int         TOSC_CLKS   = (TOSC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] INHIBIT_CYC = 2'h2;           // instruction cycles

  // instruction-cycle phases, one oscillator period each
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} tc_phase_t;

endpackage

`default_nettype wire

// ===== core/tc_prescaler.sv
// shared eight-bit prescaler with selectable ratio
`default_nettype none

module tc_prescaler (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clr,        // clear the count
  input  wire logic                  cnt_en,     // one source event
  input  wire logic [tc_pkg::PS_W-1:0] ratio,    // 0 gives 1:2 ... 7 gives 1:256
  output logic                       out_level,  // divided, symmetric level
  output logic                       tick        // one pulse per full ratio
);

  logic [7:0] cnt_ff;   // never visible to software
  logic [7:0] mask;     // low bits that make up one ratio period

  // ones in the low ratio+1 bits
  function automatic logic [7:0] low_mask(input logic [tc_pkg::PS_W-1:0] r);
    logic [8:0] m;
    m = (9'h002 << r) - 9'h001;
    return m[7:0];
  endfunction

  assign mask      = low_mask(ratio);
  // last event of a period wraps the selected bit back low
  assign tick      = cnt_en && ((cnt_ff | ~mask) == 8'hFF);
  assign out_level = cnt_ff[ratio];

  //////////////////////////////////////////////////////////////////////////////
  // count; a clear wins so a side-effect clear is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 8'h00;
    end else if (clr) begin
      cnt_ff <= 8'h00;
    end else if (cnt_en) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  clear_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clr |=> cnt_ff == 8'h00) else $error("prescaler not cleared");

endmodule

`default_nettype wire

// ===== dv/tc_pulse_src.sv
// external count pulse source that drives the timer pin
`default_nettype none

module tc_pulse_src (
  input  wire logic       aclk,
  input  wire logic [3:0] hi_clks,  // high time in clocks, two or more
  input  wire logic [3:0] lo_clks,  // low time in clocks, two or more
  output logic            pin       // count pin, rests low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin = 1'b0;
  // n pulses; the caller keeps the widths legal, no short glitches
  task automatic burst(input int n);
    repeat (n) begin
      pin <= 1'b1;
      repeat (hi_clks) @(posedge aclk);
      pin <= 1'b0;
      repeat (lo_clks) @(posedge aclk);
    end
  endtask
endmodule

`default_nettype wire

// ===== dv/timer_counter_with_shared_prescaler_bench.sv
// self-checking bench for the timer/counter block
`default_nettype none

module timer_counter_with_shared_prescaler_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awa = '0, ara = '0;  // byte addresses
  logic [31:0] wd = '0, rdat;
  logic [1:0]  br, rr, rs;
  logic        awv = 1'b0, awr, wv = 1'b0, wr_rdy, bv, bry = 1'b0;
  logic        arv = 1'b0, arr, rv, rry = 1'b0, wtk = 1'b0;
  logic        pin, wto, wclr, irq;
  logic [5:0]  pdir;
  logic [3:0]  hi = 4'h2, lo = 4'h2;
  logic [3:0]  ws = 4'hF;  // write strobes
  logic [7:0]  a, b;
  int          errors, checks, seed, wdc, wtc, n;

  tc_timer_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .external_count_input(pin), .watchdog_tick(wtk), .watchdog_timeout(wto),
    .watchdog_clear(wclr), .timer_irq_req(irq), .pin_direction(pdir));
  tc_pulse_src src_u (.aclk(aclk), .hi_clks(hi), .lo_clks(lo), .pin(pin));

  always #2 aclk = ~aclk;
  // count watchdog clear pulses seen at the port
  always @(posedge aclk) if (wclr === 1'b1) wdc <= wdc + 1;
  // count watchdog timeout pulses seen at the port
  always @(posedge aclk) if (wto === 1'b1) wtc <= wtc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // expected increments over cyc clocks with a divider of div
  function automatic logic [7:0] incs(input int cyc, input int div);
    return 8'(cyc / (4 * div));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bus write; handshake states sampled mid-cycle, released at the edge
  task automatic wrr(input logic [7:0] i, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awa <= {2'h0, i, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge aclk);
      {ta, tw, tb, rs} = {awv & awr, wv & wr_rdy, bv, br};
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) begin
        bry <= 1'b0;
        return;
      end
    end
    errors++;
    print_verdict();
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    logic ta, tb;
    @(posedge aclk);
    ara <= {2'h0, i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge aclk);
      {ta, tb, d, rs} = {arv & arr, rv, rdat[7:0], rr};
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tb) begin
        rry <= 1'b0;
        return;
      end
    end
    errors++;
    print_verdict();
  endtask
  // timer advance between two reads taken p clocks apart
  task automatic gap(input int p, output logic [7:0] d);
    logic [7:0] x;
    rd(tc_pkg::IDX_TIMER, x);
    repeat (p - 3) @(posedge aclk);
    rd(tc_pkg::IDX_TIMER, d);
    d = d - x;
  endtask
  // eight one-cycle watchdog ticks; timeouts counted in wtc from n
  task automatic ticks();
    n = wtc;
    repeat (8) begin
      wtk <= 1'b1;
      @(posedge aclk);
      wtk <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h63E75987;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(tc_pkg::IDX_OPTION, a);
    chk(a, tc_pkg::RST_OPTION);
    rd(tc_pkg::IDX_TIMER, a);
    chk(a, tc_pkg::RST_TIMER);
    chk(pdir, tc_pkg::RST_PINDIR);
    rd(8'h02, a);  // unmapped slot
    chk(rs, tc_pkg::RESP_DE);
    chk(a, 8'h00);
    ws <= 4'h0;
    wrr(tc_pkg::IDX_PINDIR, 8'h15);  // low lane off: ignored
    chk(pdir, tc_pkg::RST_PINDIR);
    chk(rs, tc_pkg::RESP_OK);
    ws <= 4'hF;
    wrr(tc_pkg::IDX_PINDIR, 8'h15);
    chk(pdir, 6'h15);
    wrr(8'h02, 8'h00);
    chk(rs, tc_pkg::RESP_DE);
    $display("reset test done");
    wrr(tc_pkg::IDX_OPTION, 8'h08);  // internal source, prescaler on watchdog
    wrr(tc_pkg::IDX_TIMER, 8'h40);
    rd(tc_pkg::IDX_TIMER, a);
    chk(a, 8'h40);
    repeat (12) @(posedge aclk);
    gap(40, b);
    chk(b, incs(40, 1));
    // every ratio; the timer write also restarts the prescaler
    for (int r = 0; r < 8; r++) begin
      wrr(tc_pkg::IDX_OPTION, 8'(r));
      wrr(tc_pkg::IDX_TIMER, 8'($random(seed)));
      repeat (12) @(posedge aclk);
      gap(8 << (r + 1), b);
      chk(b, incs(8 << (r + 1), 2 << r));
    end
    $display("internal test done");
    wrr(tc_pkg::IDX_OPTION, 8'h08);
    wrr(tc_pkg::IDX_INTCTL, 8'h00);
    wrr(tc_pkg::IDX_TIMER, 8'hFE);
    repeat (40) @(posedge aclk);
    rd(tc_pkg::IDX_INTCTL, a);
    chk(a, 8'h04);
    chk(irq, 1'b0);
    wrr(tc_pkg::IDX_INTCTL, 8'h00);  // flag cleared first
    wrr(tc_pkg::IDX_INTCTL, 8'h20);  // then enabled
    chk(irq, 1'b0);
    wrr(tc_pkg::IDX_TIMER, 8'hFE);
    repeat (40) @(posedge aclk);
    chk(irq, 1'b1);
    wrr(tc_pkg::IDX_INTCTL, 8'h20);
    chk(irq, 1'b0);
    wrr(tc_pkg::IDX_CTRL, 8'h01);
    gap(40, b);
    chk(b, 8'h00);
    wrr(tc_pkg::IDX_CTRL, 8'h00);
    n = wdc;
    wrr(tc_pkg::IDX_CTRL, 8'h02);
    repeat (4) @(posedge aclk);
    chk(32'(wdc - n), 1);
    $display("overflow and sleep test done");
    // pin counting on rising, falling, then rising through the 1:4 prescaler
    for (int e = 0; e < 3; e++) begin
      n = 1 + $unsigned($random(seed)) % 8;
      hi = 4'(2 + $unsigned($random(seed)) % 4);
      lo = 4'(2 + $unsigned($random(seed)) % 4);
      wrr(tc_pkg::IDX_OPTION, e == 2 ? 8'h21 : (e == 1 ? 8'h38 : 8'h28));
      wrr(tc_pkg::IDX_TIMER, 8'h00);
      repeat (12) @(posedge aclk);
      src_u.burst(e == 2 ? 4 * n : n);
      repeat (8) @(posedge aclk);
      rd(tc_pkg::IDX_TIMER, a);
      chk(a, 8'(n));
    end
    $display("external test done");
    // watchdog ticks pass whole while the prescaler serves the timer
    ticks();
    chk(32'(wtc - n), 8);
    wrr(tc_pkg::IDX_TIMER, 8'h00);
    wrr(tc_pkg::IDX_CTRL, 8'h02);
    wrr(tc_pkg::IDX_OPTION, 8'h08);
    ticks();
    chk(32'(wtc - n), 4);
    $display("watchdog test done");
    print_verdict();
  end
endmodule

`default_nettype wire
